// ### lsp_defs.vh
// Purpose: constants for the local-oscillator synthesiser control block
// Assumes: 8-bit register port, 100 MHz mclk
// Notes: definitions only
`ifndef LSP_DEFS_VH
`define LSP_DEFS_VH

// write addresses
`define LSP_A_RESET 8'h10
`define LSP_A_GENCTL 8'h11
`define LSP_A_RXCTL 8'h12
`define LSP_A_MDIV0 8'h20
`define LSP_A_MDIV1 8'h21
`define LSP_A_MDIV2 8'h22
`define LSP_A_RDIV0 8'h23
`define LSP_A_RDIV1 8'h24
`define LSP_A_VCOCTL 8'h25
// read-only mirror addresses
`define LSP_A_GENCTL_RD 8'he1
`define LSP_A_RXCTL_RD 8'he2
`define LSP_A_MDIV0_RD 8'hd0
`define LSP_A_MDIV1_RD 8'hd1
`define LSP_A_MDIV2_RD 8'hd2
`define LSP_A_RDIV0_RD 8'hd3
`define LSP_A_RDIV1_RD 8'hd4
`define LSP_A_VCOCTL_RD 8'hd5
// interrupt status and mask, read and write
`define LSP_A_IRQSTAT 8'h30
`define LSP_A_IRQMASK 8'h31

// field positions
`define LSP_GEN_SYNTH_EN 2
`define LSP_GEN_VCO_EN 3
`define LSP_M2_PLL_EN 7
`define LSP_M2_LOCK 6
`define LSP_RX_BW_LO 3
`define LSP_RX_BW_HI 4
`define LSP_VCO_AMP_LO 2
`define LSP_VCO_AMP_HI 3
`define LSP_VCO_CAL_OFF 7
`define LSP_IRQ_LOCKED 0
`define LSP_IRQ_UNLOCKED 1

// reset values
`define LSP_RST_BYTE 8'h00
`define LSP_RST_IRQ 2'h0

// timing: alignment window and lock confirmation
`define LSP_LOCK_WIN_NS 40
`define LSP_CLK_NS 10
`define LSP_LOCK_WIN_CYC (`LSP_LOCK_WIN_NS / `LSP_CLK_NS)
`define LSP_LOCK_CMP 8

`endif

// ### lsp_divider.v
// Purpose: programmable integer divider of input ticks
// Assumes: tick is a one-cycle pulse on mclk
// Notes: a value of 0 or 1 passes every tick
`timescale 1ns/1ns
module lsp_divider #(
  parameter WIDTH = 16
) (
  input wire mclk,
  input wire rst_b,
  input wire enable,
  input wire tick,
  input wire [WIDTH-1:0] divValue,
  output reg pulse
);
  reg [WIDTH-1:0] count;
  wire lastTick;

  assign lastTick = (divValue <= {{(WIDTH-1){1'b0}}, 1'b1}) ||
                    (count >= divValue - {{(WIDTH-1){1'b0}}, 1'b1});

  // count ticks and emit one pulse per divValue ticks
  always @(posedge mclk) begin
    if (!rst_b || !enable) begin
      count <= {WIDTH{1'b0}};
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (lastTick) begin
          count <= {WIDTH{1'b0}};
          pulse <= 1'b1;
        end else begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ### lsp_phase_det.v
// Purpose: phase-frequency detector with lock detection
// Assumes: refPulse and fbPulse are one-cycle pulses
// Notes: pump outputs are zero while disabled
`timescale 1ns/1ns
`include "lsp_defs.vh"
module lsp_phase_det #(
  parameter LOCK_CMP = `LSP_LOCK_CMP,
  parameter LOCK_WIN = `LSP_LOCK_WIN_CYC
) (
  input wire mclk,
  input wire rst_b,
  input wire enable,
  input wire refPulse,
  input wire fbPulse,
  output reg pumpUp,
  output reg pumpDown,
  output reg locked
);
  reg [7:0] gap;
  reg [7:0] goodCount;
  wire bothSeen;
  wire next_up;
  wire next_down;

  assign next_up = (pumpUp | refPulse);
  assign next_down = (pumpDown | fbPulse);
  assign bothSeen = next_up & next_down;

  always @(posedge mclk) begin
    if (!rst_b || !enable) begin
      pumpUp <= 1'b0;
      pumpDown <= 1'b0;
      gap <= 8'h00;
      goodCount <= 8'h00;
      locked <= 1'b0;
    end else begin
      // reference first: feedback slow, raise tuning voltage
      if (bothSeen) begin
        pumpUp <= 1'b0;
        pumpDown <= 1'b0;
        gap <= 8'h00;
        if (gap <= LOCK_WIN[7:0]) begin
          if (goodCount >= LOCK_CMP[7:0] - 8'h01) begin
            locked <= 1'b1;
          end else begin
            goodCount <= goodCount + 8'h01;
          end
        end else begin
          goodCount <= 8'h00;
          locked <= 1'b0;
        end
      end else begin
        pumpUp <= next_up;
        pumpDown <= next_down;
        if (next_up | next_down) begin
          gap <= (gap == 8'hff) ? gap : gap + 8'h01;
        end
      end
    end
  end
endmodule

// ### lsp_pll_control.v
// Purpose: register file and integer-N synthesiser control
// Assumes: plain register port, one synchronous active-low reset
// Notes: reference and feedback pins are resynchronised to mclk
// Operation
// - synthesiser runs only when both enable bits set
// - output locks to reference times M over R
// - feedback and reference dividers from own registers
// - phase detector off gives high-impedance pump
// - positive tuning slope: reference first pumps up
// - lock status reads at feedback-top bit six
// - two VCO bits tune negative-resistance amplifier
// - VCO bit seven disables filter calibration
// - bandwidth select in fixed 1:2:4 steps
// - feedback divider: three write, three mirror bytes
// - reference divider: two write, two mirror bytes
`timescale 1ns/1ns
`include "lsp_defs.vh"
module lsp_pll_control #(
  parameter M_WIDTH = 22,
  parameter R_WIDTH = 16,
  parameter LOCK_CMP = `LSP_LOCK_CMP
) (
  input wire mclk,
  input wire rst_b,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire ref_clock_in,
  input wire fbClockIn,
  output wire chargeOut,
  output wire chargeOe,
  output wire synthActive,
  output wire synthLocked,
  output wire vcoEnable,
  output wire [1:0] vcoAmpTune,
  output wire filterCalOff,
  output wire [1:0] bandwidthSel,
  output wire [2:0] bandwidthScale,
  output wire [7:0] genControl,
  output wire [7:0] rxControl,
  output wire irq
);
  reg [7:0] genCtl;
  reg [7:0] rxCtl;
  reg [7:0] mDiv0;
  reg [7:0] mDiv1;
  reg [7:0] mDiv2;
  reg [7:0] rDiv0;
  reg [7:0] rDiv1;
  reg [7:0] vcoCtl;
  reg [1:0] irqStatus;
  reg [1:0] irqMask;

  reg refSync1;
  reg refSync2;
  reg refLast;
  reg fbSync1;
  reg fbSync2;
  reg fbLast;
  reg lockLast;

  wire generalReset;
  wire detRst_b;
  wire pllEnable;
  wire refTick;
  wire fbTick;
  wire refDivPulse;
  wire fbDivPulse;
  wire pumpUp;
  wire pumpDown;
  wire locked;
  wire lockRise;
  wire lockFall;
  wire [M_WIDTH-1:0] mValue;
  wire [R_WIDTH-1:0] rValue;
  wire [1:0] irqEvents;
  wire [1:0] irqClear;
  reg [7:0] next_rdata;

  // address-only write to the reset address clears every register
  assign generalReset = regWrite && (regAddr == `LSP_A_RESET);

  // general reset also clears the lock flag, so no stale lock event follows
  assign detRst_b = rst_b & ~generalReset;

  // both enable bits must be one
  assign pllEnable = genCtl[`LSP_GEN_SYNTH_EN] & mDiv2[`LSP_M2_PLL_EN];

  // divider values from their own write registers
  assign mValue = {mDiv2[5:0], mDiv1, mDiv0};
  assign rValue = {rDiv1, rDiv0};

  // register writes
  always @(posedge mclk) begin
    if (!rst_b || generalReset) begin
      genCtl <= `LSP_RST_BYTE;
      rxCtl <= `LSP_RST_BYTE;
      mDiv0 <= `LSP_RST_BYTE;
      mDiv1 <= `LSP_RST_BYTE;
      mDiv2 <= `LSP_RST_BYTE;
      rDiv0 <= `LSP_RST_BYTE;
      rDiv1 <= `LSP_RST_BYTE;
      vcoCtl <= `LSP_RST_BYTE;
      irqMask <= `LSP_RST_IRQ;
    end else if (regWrite) begin
      case (regAddr)
        `LSP_A_GENCTL: begin
          genCtl <= regWdata;
        end
        `LSP_A_RXCTL: begin
          rxCtl <= regWdata;
        end
        `LSP_A_MDIV0: begin
          mDiv0 <= regWdata;
        end
        `LSP_A_MDIV1: begin
          mDiv1 <= regWdata;
        end
        `LSP_A_MDIV2: begin
          mDiv2 <= regWdata;
        end
        `LSP_A_RDIV0: begin
          rDiv0 <= regWdata;
        end
        `LSP_A_RDIV1: begin
          rDiv1 <= regWdata;
        end
        `LSP_A_VCOCTL: begin
          vcoCtl <= regWdata;
        end
        `LSP_A_IRQMASK: begin
          irqMask <= regWdata[1:0];
        end
        default: begin
          genCtl <= genCtl;
        end
      endcase
    end
  end

  // read data, valid the cycle after the read strobe
  always @* begin
    next_rdata = 8'h00;
    case (regAddr)
      `LSP_A_GENCTL_RD: begin
        next_rdata = genCtl;
      end
      `LSP_A_RXCTL_RD: begin
        next_rdata = rxCtl;
      end
      `LSP_A_MDIV0_RD: begin
        next_rdata = mDiv0;
      end
      `LSP_A_MDIV1_RD: begin
        next_rdata = mDiv1;
      end
      `LSP_A_MDIV2_RD: begin
        next_rdata = {mDiv2[7], locked, mDiv2[5:0]};
      end
      `LSP_A_RDIV0_RD: begin
        next_rdata = rDiv0;
      end
      `LSP_A_RDIV1_RD: begin
        next_rdata = rDiv1;
      end
      `LSP_A_VCOCTL_RD: begin
        next_rdata = vcoCtl;
      end
      `LSP_A_IRQSTAT: begin
        next_rdata = {6'h00, irqStatus};
      end
      `LSP_A_IRQMASK: begin
        next_rdata = {6'h00, irqMask};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // two-stage synchronisers for the reference and feedback pins
  always @(posedge mclk) begin
    if (!rst_b) begin
      refSync1 <= 1'b0;
      refSync2 <= 1'b0;
      refLast <= 1'b0;
      fbSync1 <= 1'b0;
      fbSync2 <= 1'b0;
      fbLast <= 1'b0;
    end else begin
      refSync1 <= ref_clock_in;
      refSync2 <= refSync1;
      refLast <= refSync2;
      fbSync1 <= fbClockIn;
      fbSync2 <= fbSync1;
      fbLast <= fbSync2;
    end
  end

  assign refTick = refSync2 & ~refLast;
  assign fbTick = fbSync2 & ~fbLast;

  // reference divider R
  lsp_divider #(
    .WIDTH(R_WIDTH)
  ) refDivider (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(pllEnable),
    .tick(refTick),
    .divValue(rValue),
    .pulse(refDivPulse)
  );

  // feedback divider M
  lsp_divider #(
    .WIDTH(M_WIDTH)
  ) fbDivider (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(pllEnable),
    .tick(fbTick),
    .divValue(mValue),
    .pulse(fbDivPulse)
  );

  // comparing ref/R with fb/M drives fout to ref_clock_in*M/R
  lsp_phase_det #(
    .LOCK_CMP(LOCK_CMP),
    .LOCK_WIN(`LSP_LOCK_WIN_CYC)
  ) phaseDet (
    .mclk(mclk),
    .rst_b(detRst_b),
    .enable(pllEnable),
    .refPulse(refDivPulse),
    .fbPulse(fbDivPulse),
    .pumpUp(pumpUp),
    .pumpDown(pumpDown),
    .locked(locked)
  );

  // pump drives only while enabled and correcting, else high impedance
  assign chargeOe = pllEnable & (pumpUp ^ pumpDown);
  assign chargeOut = pumpUp & ~pumpDown;

  assign synthActive = pllEnable;
  assign synthLocked = locked;

  // lock events into sticky status, set wins over clear
  always @(posedge mclk) begin
    if (!rst_b || generalReset) begin
      lockLast <= 1'b0;
    end else begin
      lockLast <= locked;
    end
  end

  assign lockRise = locked & ~lockLast;
  assign lockFall = ~locked & lockLast;
  assign irqEvents = {lockFall, lockRise};
  assign irqClear = (regWrite && regAddr == `LSP_A_IRQSTAT) ? regWdata[1:0] : 2'h0;

  always @(posedge mclk) begin
    if (!rst_b || generalReset) begin
      irqStatus <= `LSP_RST_IRQ;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // VCO amplifier tuning takes effect only with the VCO enabled
  assign vcoEnable = genCtl[`LSP_GEN_VCO_EN];
  assign vcoAmpTune = vcoEnable ? vcoCtl[`LSP_VCO_AMP_HI:`LSP_VCO_AMP_LO] : 2'h0;
  assign filterCalOff = vcoCtl[`LSP_VCO_CAL_OFF];

  // bandwidth select: 00 x1, 01 x2, 10 x4, 11 reserved held at x1
  assign bandwidthSel = rxCtl[`LSP_RX_BW_HI:`LSP_RX_BW_LO];
  assign bandwidthScale = (bandwidthSel == 2'h1) ? 3'h2 :
                          (bandwidthSel == 2'h2) ? 3'h4 : 3'h1;

  assign genControl = genCtl;
  assign rxControl = rxCtl;
endmodule

// ### lsp_osc_model.sv
// Purpose: reference and feedback oscillator model for the synthesiser pins
// Assumes: pin half period of 8 mclk cycles, slower than mclk/4
// Notes: fbStuck holds the feedback pin low to starve the divider
`timescale 1ns/1ns
module lsp_osc_model (
  input wire mclk,
  input wire fbStuck,
  output wire refPin,
  output wire fbPin
);
  logic [3:0] cnt = 4'h0;
  always @(posedge mclk) begin
    cnt <= cnt + 4'h1;
  end
  assign refPin = cnt[3];
  // feedback follows reference so that divided edges line up
  assign fbPin = fbStuck ? 1'b0 : cnt[3];
endmodule

// ### lsp_pll_control_sva.sv
// Purpose: port-level checks of the synthesiser control block
// Assumes: single mclk domain, rst_b synchronous active low
// Notes: bound to lsp_pll_control
`timescale 1ns/1ns
module lsp_pll_checker (
  input wire mclk,
  input wire rst_b,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata,
  input wire chargeOe,
  input wire synthActive,
  input wire synthLocked,
  input wire vcoEnable,
  input wire [1:0] vcoAmpTune,
  input wire filterCalOff,
  input wire [1:0] bandwidthSel,
  input wire [2:0] bandwidthScale,
  input wire [7:0] genControl,
  input wire irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_enable_needs_gen: assert property (synthActive |-> genControl[2])
    else $error("synth active without enable bit");
  a_pump_off_idle: assert property (!synthActive |-> !chargeOe)
    else $error("pump driving while disabled");
  a_mdiv_wo_read: assert property (regRead && regAddr == 8'h20 |=> regRdata == 8'h00)
    else $error("write-only feedback byte read back");
  a_rdiv_wo_read: assert property (regRead && regAddr == 8'h23 |=> regRdata == 8'h00)
    else $error("write-only reference byte read back");
  a_lock_readback: assert property ((regRead && regAddr == 8'hd2 && synthLocked) ##1 synthLocked
    |-> regRdata[6])
    else $error("lock bit missing in readback");
  a_amp_needs_vco: assert property (vcoAmpTune != 2'h0 |-> vcoEnable)
    else $error("amp tune without vco enable");
  a_cal_off_write: assert property (regWrite && regAddr == 8'h25
    |=> filterCalOff == $past(regWdata[7]))
    else $error("calibration disable not taken");
  a_bw_ratio: assert property (bandwidthScale == (bandwidthSel == 2'h1 ? 3'h2 :
    bandwidthSel == 2'h2 ? 3'h4 : 3'h1))
    else $error("bandwidth scale wrong");
  a_lock_when_on: assert property ($rose(synthLocked) |-> synthActive)
    else $error("lock gained while disabled");
  a_gen_write: assert property (regWrite && regAddr == 8'h11 |=> genControl == $past(regWdata))
    else $error("general control write lost");
  c_lock: cover property ($rose(synthLocked));
  c_pump: cover property (chargeOe);
  c_irq: cover property (irq);
endmodule
bind lsp_pll_control lsp_pll_checker chk_u (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .chargeOe(chargeOe), .synthActive(synthActive), .synthLocked(synthLocked),
  .vcoEnable(vcoEnable), .vcoAmpTune(vcoAmpTune), .filterCalOff(filterCalOff),
  .bandwidthSel(bandwidthSel), .bandwidthScale(bandwidthScale), .genControl(genControl),
  .irq(irq));

// ### testbench.sv
// Purpose: register and lock scenarios for the synthesiser control block
// Assumes: 100 MHz mclk, lock count shortened to 2
// Notes: oscillator pins come from lsp_osc_model
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0, fbStuck = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
  wire [7:0] regRdata, genControl, rxControl;
  wire refPin, fbPin, chargeOut, chargeOe, synthActive, synthLocked, vcoEnable;
  wire filterCalOff, irq;
  wire [1:0] vcoAmpTune, bandwidthSel;
  wire [2:0] bandwidthScale;
  int n_errors = 0, checked = 0, cyc = 0, i;
  logic [7:0] zeroAddr [12] = '{8'he1, 8'he2, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5,
    8'h30, 8'h31, 8'h20, 8'h7f};
  always #5 mclk = ~mclk;
  lsp_osc_model osc_u (.mclk(mclk), .fbStuck(fbStuck), .refPin(refPin), .fbPin(fbPin));
  lsp_pll_control #(.LOCK_CMP(2)) dut_u (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .ref_clock_in(refPin), .fbClockIn(fbPin), .chargeOut(chargeOut), .chargeOe(chargeOe),
    .synthActive(synthActive), .synthLocked(synthLocked), .vcoEnable(vcoEnable),
    .vcoAmpTune(vcoAmpTune), .filterCalOff(filterCalOff), .bandwidthSel(bandwidthSel),
    .bandwidthScale(bandwidthScale), .genControl(genControl), .rxControl(rxControl), .irq(irq));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) begin
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
    end
    @(posedge mclk) regWrite <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) begin
      regAddr <= a;
      regRead <= 1'b1;
    end
    @(posedge mclk) regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task wait_lock(input logic want);
    for (i = 0; i < 2000 && synthLocked !== want; i++) @(negedge mclk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (zeroAddr[k]) rd(zeroAddr[k], 8'h00);
    $display("test reset values done");
    wr(8'h11, 8'h0c);
    rd(8'he1, 8'h0c);
    chk({7'h0, synthActive}, 8'h00);
    wr(8'h20, 8'h02);
    wr(8'h23, 8'h02);
    wr(8'h22, 8'h80);
    chk({7'h0, synthActive}, 8'h01);
    rd(8'hd0, 8'h02);
    rd(8'hd2, 8'h80);
    rd(8'hd3, 8'h02);
    rd(8'h23, 8'h00);
    wr(8'hd3, 8'h55);
    rd(8'hd3, 8'h02);
    wr(8'h25, 8'h8c);
    chk({6'h0, vcoAmpTune}, 8'h03);
    chk({7'h0, filterCalOff}, 8'h01);
    rd(8'hd5, 8'h8c);
    for (int b = 0; b < 4; b++) begin
      wr(8'h12, 8'(b << 3));
      chk(rxControl, 8'(b << 3));
      chk({6'h0, bandwidthSel}, 8'(b));
      chk({5'h0, bandwidthScale}, 8'(b == 3 ? 1 : 1 << b));
    end
    chk(genControl, 8'h0c);
    chk({7'h0, vcoEnable}, 8'h01);
    wr(8'h11, 8'h04);
    chk({6'h0, vcoAmpTune}, 8'h00);
    chk({7'h0, synthActive}, 8'h01);
    wr(8'h11, 8'h0c);
    chk({6'h0, vcoAmpTune}, 8'h03);
    $display("test registers done");
    wait_lock(1'b1);
    chk({7'h0, synthLocked}, 8'h01);
    rd(8'hd2, 8'hc0);
    chk({7'h0, irq}, 8'h00);
    rd(8'h30, 8'h01);
    wr(8'h31, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(8'h30, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(8'h20, 8'h03);
    wait_lock(1'b0);
    chk({7'h0, synthLocked}, 8'h00);
    rd(8'h30, 8'h02);
    $display("test lock done");
    @(posedge mclk) fbStuck <= 1'b1;
    repeat (100) @(posedge mclk);
    #1 chk({6'h0, chargeOe, chargeOut}, 8'h03);
    wr(8'h11, 8'h00);
    chk({6'h0, chargeOe, synthActive}, 8'h00);
    wr(8'h10, 8'h00);
    rd(8'hd0, 8'h00);
    rd(8'hd5, 8'h00);
    rd(8'he1, 8'h00);
    rd(8'h30, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test pump and reset done");
    stop_test;
  end
endmodule
